// [design/audio_port_pin_direction.sv]
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps

module audio_port_pin_direction
#(
  parameter int data_pin_count = pin_dir_pkg::serial_data_count
)
(
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   clk_en,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output pin_dir_pkg::pad_ctrl_s      pad_oe,
  output pin_dir_pkg::pad_ctrl_s      pad_func_reserved
);

  // ==========================================================================
  // register state
  // ==========================================================================
  logic [31:0] pin_direction_reg_q;
  logic [31:0] pin_direction_reg_d;
  logic [31:0] pin_function_select_q;
  logic [31:0] pin_function_select_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;

  function automatic logic [31:0] lane_merge
  (
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res & pin_dir_pkg::implemented_mask;
  endfunction

  logic access;
  logic setup;
  logic hit_dir;
  logic hit_func;

  assign access   = psel && penable;
  assign setup    = psel && !penable;
  assign hit_dir  = (paddr == pin_dir_pkg::pin_direction_offset);
  assign hit_func = (paddr == pin_dir_pkg::function_select_offset);
  assign pready   = 1'b1;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    pin_direction_reg_d   = pin_direction_reg_q;
    pin_function_select_d = pin_function_select_q;
    prdata_d              = 32'h00000000;
    pslverr_d             = 1'b0;
    // the answer is built in the setup cycle so it can leave flops in the
    // access cycle with no wait state, and falls back to zero after it
    if (setup)
    begin
      pslverr_d = !(hit_dir || hit_func);
      if (!pwrite && hit_dir)
      begin
        prdata_d = pin_direction_reg_q & pin_dir_pkg::implemented_mask;
      end
      else if (!pwrite && hit_func)
      begin
        prdata_d = pin_function_select_q & pin_dir_pkg::implemented_mask;
      end
    end
    if (access && pwrite)
    begin
      // reserved lanes masked off so stray writes cannot stick
      if (hit_dir)
      begin
        pin_direction_reg_d = lane_merge(pin_direction_reg_q, pwdata, pstrb);
      end
      else if (hit_func)
      begin
        pin_function_select_d = lane_merge(pin_function_select_q, pwdata, pstrb);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pin_direction_reg_q   <= pin_dir_pkg::pin_direction_reset;
      pin_function_select_q <= pin_dir_pkg::function_select_reset;
      prdata_q              <= 32'h00000000;
      pslverr_q             <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_direction_reg_q   <= pin_direction_reg_d;
      pin_function_select_q <= pin_function_select_d;
      prdata_q              <= prdata_d;
      pslverr_q             <= pslverr_d;
    end
  end

  // answer leaves flops; a transfer whose setup edge fell with the clock
  // enable low returns a stale answer, so software must not read while frozen
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // parameter check
  // ==========================================================================
  // the pad carrier has four data pin slots; no other count can be served
  if (data_pin_count != pin_dir_pkg::serial_data_count)
  begin : g_bad_count
    $error("data pin count must equal the pad carrier width");
  end

  // ==========================================================================
  // pad enables
  // ==========================================================================
  // enables come straight from flops; function select cannot override them
  always_comb
  begin
    pad_oe.rx_frame_sync      = pin_direction_reg_q[pin_dir_pkg::rx_frame_sync_bit];
    pad_oe.rx_high_freq_clock = pin_direction_reg_q[pin_dir_pkg::rx_high_freq_clock_bit];
    pad_oe.rx_bit_clock       = pin_direction_reg_q[pin_dir_pkg::rx_bit_clock_bit];
    pad_oe.tx_frame_sync      = pin_direction_reg_q[pin_dir_pkg::tx_frame_sync_bit];
    pad_oe.tx_high_freq_clock = pin_direction_reg_q[pin_dir_pkg::tx_high_freq_clock_bit];
    pad_oe.tx_bit_clock       = pin_direction_reg_q[pin_dir_pkg::tx_bit_clock_bit];
    pad_oe.mute_request       = pin_direction_reg_q[pin_dir_pkg::mute_request_bit];
    pad_oe.serial_data        = pin_direction_reg_q[pin_dir_pkg::serial_data_lsb +:
                                                    data_pin_count];
  end

  // a set bit flags the reserved selection so the pad mux can report it
  always_comb
  begin
    pad_func_reserved.rx_frame_sync      = pin_function_select_q[31];
    pad_func_reserved.rx_high_freq_clock = pin_function_select_q[30];
    pad_func_reserved.rx_bit_clock       = pin_function_select_q[29];
    pad_func_reserved.tx_frame_sync      = pin_function_select_q[28];
    pad_func_reserved.tx_high_freq_clock = pin_function_select_q[27];
    pad_func_reserved.tx_bit_clock       = pin_function_select_q[26];
    pad_func_reserved.mute_request       = pin_function_select_q[25];
    pad_func_reserved.serial_data        = pin_function_select_q[3:0];
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  property p_dir_write;
    @(posedge clock) disable iff (srst)
      (clk_en && access && pwrite && hit_dir && pstrb == 4'hF)
      |=> (pad_oe.serial_data == $past(pwdata[3:0]));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("data pin enable not updated");

  property p_top_bits;
    @(posedge clock) disable iff (srst)
      (clk_en && access && pwrite && hit_dir && pstrb[3])
      |=> (pin_direction_reg_q[31:25] == $past(pwdata[31:25]));
  endproperty
  a_top_bits: assert property (p_top_bits) else $error("clock/sync enable not updated");

  property p_reserved_zero;
    @(posedge clock) disable iff (srst)
      (pin_direction_reg_q[24:4] == 21'h000000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_read_reserved;
    @(posedge clock) disable iff (srst)
      (access && !pwrite && hit_dir) |-> (prdata[24:4] == 21'h000000);
  endproperty
  a_read_reserved: assert property (p_read_reserved) else $error("reserved read nonzero");

  property p_reset_input;
    @(posedge clock) $past(srst) |-> (pad_oe == '0);
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pin driven after reset");

  property p_rfs;
    @(posedge clock) disable iff (srst)
      pad_oe.rx_frame_sync == pin_direction_reg_q[31] && pad_oe.rx_high_freq_clock
      == pin_direction_reg_q[30] && pad_oe.rx_bit_clock == pin_direction_reg_q[29];
  endproperty
  a_rfs: assert property (p_rfs) else $error("receive pin enable mismatch");

  property p_tx;
    @(posedge clock) disable iff (srst)
      pad_oe.tx_frame_sync == pin_direction_reg_q[28] && pad_oe.tx_high_freq_clock
      == pin_direction_reg_q[27] && pad_oe.tx_bit_clock == pin_direction_reg_q[26];
  endproperty
  a_tx: assert property (p_tx) else $error("transmit pin enable mismatch");

  property p_mute;
    @(posedge clock) disable iff (srst)
      pad_oe.mute_request == pin_direction_reg_q[25];
  endproperty
  a_mute: assert property (p_mute) else $error("mute enable mismatch");

  property p_func_indep;
    @(posedge clock) disable iff (srst)
      (clk_en && access && pwrite && hit_func) |=> $stable(pad_oe);
  endproperty
  a_func_indep: assert property (p_func_indep) else $error("function write moved enable");

  property p_hold;
    @(posedge clock) disable iff (srst)
      (!clk_en) |=> $stable(pin_direction_reg_q);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved with clock enable low");

  // answers are judged only for transfers whose setup edge was enabled and
  // out of reset; a frozen setup edge leaves a stale answer by design
  property p_err_resp;
    @(posedge clock) disable iff (srst)
      (access && $past(clk_en) && !$past(srst))
      |-> (pslverr == !(hit_dir || hit_func));
  endproperty
  a_err_resp: assert property (p_err_resp) else $error("error response wrong for address");

  property p_read_dir;
    @(posedge clock) disable iff (srst)
      (access && !pwrite && hit_dir && $past(clk_en) && !$past(srst))
      |-> (prdata == (pin_direction_reg_q & 32'hFE00000F));
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("direction read data wrong");

  property p_read_func;
    @(posedge clock) disable iff (srst)
      (access && !pwrite && hit_func && $past(clk_en) && !$past(srst))
      |-> (prdata == (pin_function_select_q & 32'hFE00000F));
  endproperty
  a_read_func: assert property (p_read_func) else $error("function read data wrong");

  property p_strb_keep;
    @(posedge clock) disable iff (srst)
      (clk_en && access && pwrite && hit_dir && !pstrb[0]) |=> $stable(pad_oe.serial_data);
  endproperty
  a_strb_keep: assert property (p_strb_keep) else $error("disabled lane moved data pins");

  property p_unmapped_keep;
    @(posedge clock) disable iff (srst)
      (clk_en && access && pwrite && !hit_dir && !hit_func) |=> $stable(pin_direction_reg_q);
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep) else $error("unmapped write moved enables");

  property p_read_keep;
    @(posedge clock) disable iff (srst)
      (clk_en && access && !pwrite) |=> $stable(pin_direction_reg_q);
  endproperty
  a_read_keep: assert property (p_read_keep) else $error("read moved enables");

  property p_hold_func;
    @(posedge clock) disable iff (srst)
      (!clk_en) |=> $stable(pin_function_select_q);
  endproperty
  a_hold_func: assert property (p_hold_func) else $error("function select moved while frozen");

  property p_reset_func;
    @(posedge clock) $past(srst) |-> (pad_func_reserved == '0);
  endproperty
  a_reset_func: assert property (p_reset_func) else $error("reserved selection after reset");

  c_dir_write: cover property (@(posedge clock) access && pwrite && hit_dir);
  c_dir_read: cover property (@(posedge clock) access && !pwrite && hit_dir);
  c_bad_addr: cover property (@(posedge clock) access && pslverr);
  c_all_out: cover property (@(posedge clock) pad_oe == '1);
  // a write lost to the frozen clock enable
  c_frozen_write: cover property (@(posedge clock) !clk_en && access && pwrite);

endmodule

// [design/pin_dir_pkg.sv]
package pin_dir_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [11:0] function_select_offset = 12'h010;
  localparam logic [11:0] pin_direction_offset   = 12'h014;
  localparam logic [31:0] function_select_reset  = 32'h00000000;
  localparam logic [31:0] pin_direction_reset    = 32'h00000000;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int rx_frame_sync_bit      = 31;
  localparam int rx_high_freq_clock_bit = 30;
  localparam int rx_bit_clock_bit       = 29;
  localparam int tx_frame_sync_bit      = 28;
  localparam int tx_high_freq_clock_bit = 27;
  localparam int tx_bit_clock_bit       = 26;
  localparam int mute_request_bit       = 25;
  localparam int serial_data_lsb        = 0;
  localparam int serial_data_count      = 4;

  // implemented bits: 31..25 and 3..0; 24..4 read zero
  localparam logic [31:0] implemented_mask = 32'hFE00000F;

  // pad controls gathered in one carrier
  typedef struct packed
  {
    logic       rx_frame_sync;
    logic       rx_high_freq_clock;
    logic       rx_bit_clock;
    logic       tx_frame_sync;
    logic       tx_high_freq_clock;
    logic       tx_bit_clock;
    logic       mute_request;
    logic [3:0] serial_data;
  } pad_ctrl_s;

endpackage

// [tb/audio_port_pin_direction_bench.sv]
`timescale 1ns/1ps

`define CHK(name, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("unexpected %s expected %h seen %h", name, exp, got); \
    end \
  end

module audio_port_pin_direction_bench;

  // ==========================================================================
  // signals
  // ==========================================================================
  logic                   clock = 1'b0;
  logic                   srst = 1'b1;
  logic                   clk_en = 1'b1;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h00000000;
  logic [3:0]             pstrb = 4'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  pin_dir_pkg::pad_ctrl_s pad_oe;
  pin_dir_pkg::pad_ctrl_s pad_func_reserved;
  logic [31:0]            rdat;
  logic                   rerr;
  int                     rwait;
  int                     n_errors = 0;
  int                     total_checks = 0;

  localparam logic [11:0] dir_a = pin_dir_pkg::pin_direction_offset;
  localparam logic [11:0] fun_a = pin_dir_pkg::function_select_offset;
  localparam logic [31:0] mask = pin_dir_pkg::implemented_mask;

  always #2.5 clock = ~clock;

  audio_port_pin_direction DUT
  (
    .clock             (clock),
    .srst              (srst),
    .clk_en            (clk_en),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .pstrb             (pstrb),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .pad_oe            (pad_oe),
    .pad_func_reserved (pad_func_reserved)
  );

  // ==========================================================================
  // apb master: entered just after a rising edge, leaves one idle cycle behind
  // ==========================================================================
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // no limit of its own: only the watchdog ends a wait
    while (pready !== 1'b1)
    begin
      n++;
      @(posedge clock);
    end
    rwait = n;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, 4'h0);
    `CHK("read data", exp, rdat)
    `CHK("wait states", 0, rwait)
  endtask

  // pad enables come straight from the implemented direction bits
  function automatic pin_dir_pkg::pad_ctrl_s oe_of(input logic [31:0] v);
    return {v[31:25], v[3:0]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // tests
  // ==========================================================================
  initial
  begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    `CHK("pad_oe after reset", 11'h000, pad_oe)
    rd_chk(dir_a, 32'h00000000);
    rd_chk(fun_a, 32'h00000000);
    for (int i = 0; i < 32; i++)
    begin
      apb(1'b1, dir_a, 32'h00000001 << i, 4'hF);
      `CHK("pad_oe walk", oe_of(32'h00000001 << i), pad_oe)
      rd_chk(dir_a, (32'h00000001 << i) & mask);
    end
    apb(1'b1, dir_a, 32'h00000000, 4'hF);
    apb(1'b1, dir_a, 32'hFFFFFFFF, 4'h1);
    rd_chk(dir_a, 32'h0000000F);
    apb(1'b1, dir_a, 32'hFFFFFFFF, 4'h8);
    rd_chk(dir_a, 32'hFE00000F);
    `CHK("pad_oe all out", 11'h7FF, pad_oe)
    // function select must not move the enables either way
    apb(1'b1, fun_a, 32'hFFFFFFFF, 4'hF);
    `CHK("func flags", 11'h7FF, pad_func_reserved)
    `CHK("pad_oe with func", 11'h7FF, pad_oe)
    rd_chk(fun_a, mask);
    apb(1'b1, dir_a, 32'h0000000A, 4'hF);
    `CHK("pad_oe mixed", oe_of(32'h0000000A), pad_oe)
    apb(1'b1, fun_a, 32'h00000000, 4'hF);
    `CHK("func cleared", 11'h000, pad_func_reserved)
    `CHK("pad_oe stays", oe_of(32'h0000000A), pad_oe)
    // unmapped place: error response, no side effect
    apb(1'b1, 12'h020, 32'hFFFFFFFF, 4'hF);
    `CHK("slverr write", 1'b1, rerr)
    rd_chk(12'h020, 32'h00000000);
    `CHK("slverr read", 1'b1, rerr)
    rd_chk(dir_a, 32'h0000000A);
    `CHK("slverr mapped", 1'b0, rerr)
    // a write while the clock enable is low is lost
    clk_en <= 1'b0;
    apb(1'b1, dir_a, 32'h02000000, 4'hF);
    clk_en <= 1'b1;
    @(posedge clock);
    rd_chk(dir_a, 32'h0000000A);
    apb(1'b1, fun_a, 32'h80000001, 4'hF);
    // reset in mid-run returns every pin to input
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    `CHK("pad_oe reset", 11'h000, pad_oe)
    `CHK("func after reset", 11'h000, pad_func_reserved)
    rd_chk(dir_a, 32'h00000000);
    report_and_stop();
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end

endmodule
